// ==== hdl/scg_params.svh ====
// Constants for the system clock generation block.
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// Clock rate of clk_i in MHz and its period in ns.
`define SCG_CLK_MHZ        200
`define SCG_CLK_PERIOD_NS  5

// Structure of the divider chain.
`define SCG_SYS_DIV_WIDTH  8
`define SCG_CPU_DIV_WIDTH  5
`define SCG_PRE_WIDTH      13
`define SCG_CPU_SEL_MAX    3'h5

// Reset values of the applied configuration.
`define SCG_SYS_DIV_RST    8'h00
`define SCG_BASE_SEL_RST   1'h0
`define SCG_HS_SEL_RST     1'h0
`define SCG_LS_SEL_RST     1'h0

// Sub-clock pin configuration codes that let the sub-clock run.
`define SCG_SUBCLK_EXT     2'h1
`define SCG_SUBCLK_XTAL    2'h2

`endif

// ==== hdl/scg_pkg.sv ====
// Types shared by the system clock generation block.
package scg_pkg;

  typedef enum logic [1:0] {
    SCG_SW_RUN,
    SCG_SW_DRAIN,
    SCG_SW_ARM
  } scg_switch_state_type;

  typedef struct packed {
    logic base_path;
    logic high_speed;
    logic low_speed;
  } scg_src_sel_type;

endpackage : scg_pkg

// ==== hdl/scg_divider.sv ====
// Tick divider whose ratio is taken only at a period boundary.
`timescale 1ns/10ps
`default_nettype none

module scg_divider
  import scg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             tick_i,
  input  wire logic [WIDTH-1:0] ratio_m1_i,
  output logic                  tick_o
);

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("scg_divider: WIDTH must lie between 1 and 16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] ratio;
    logic             tick;
  } scg_div_state_type;

  scg_div_state_type s_q;
  scg_div_state_type s_d;

  // A new ratio waits for the end of the running period, so no output
  // interval is ever cut short.
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (tick_i) begin
      if (s_q.count == s_q.ratio) begin
        s_d.count = '0;
        s_d.tick  = 1'b1;
        s_d.ratio = ratio_m1_i;
      end else begin
        s_d.count = s_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule : scg_divider

`default_nettype wire

// ==== hdl/scg_top.sv ====
// System clock generation: source selection, dividers and prescaler.
//
// Overview of operation
// - Slow oscillator enabled and chosen on the low path as base.
// - After reset the CPU runs from the slow oscillator, undivided.
// - System clock is base clock divided by setting plus one, 1 to 256.
// - CPU clock is system clock divided by 1, 2, 4, 8, 16 or 32.
// - Peripheral clocks divide system clock to 8192; may halt in wait.
// - Fast oscillator output runs while enabled, also during wait.
// - Slow oscillator output runs while not disabled, also during wait.
// - Sub-clock runs for pin codes 01b or 10b, also in wait and stop.
// - High path picks crystal or fast oscillator by its select bit.
// - Low path picks sub-clock or slow oscillator by its select bit.
// - Converter clock divides system clock and keeps running in wait.
// - A 13-bit prescaler on the system clock feeds peripheral clocks.
// - Prescaler counts only while its halt bit is 0.
// - Prescaler halts on wait entry when wait clock stop is 1.
// - Prescaler clears on stop exit and on wait exit with clock switch.
// - Software can neither read nor write the prescaler count.
// - High path select: 0 crystal, 1 fast oscillator.
// - Base select: 1 high path, 0 low path.
// - Low path select: 1 sub-clock, 0 slow oscillator.
//
// Every clock here is a one-cycle tick on clk_i, so one flip-flop domain
// carries the whole tree and no gated clock leaves the block.
`timescale 1ns/10ps
`default_nettype none

`include "scg_params.svh"

module scg_top
  import scg_pkg::*;
#(
  parameter int SYS_DIV_WIDTH = `SCG_SYS_DIV_WIDTH,
  parameter int PRE_WIDTH     = `SCG_PRE_WIDTH
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     main_crystal_clock_i,
  input  wire logic                     sub_crystal_clock_i,
  input  wire logic                     fast_internal_clock_i,
  input  wire logic                     slow_internal_clock_i,
  input  wire logic                     fast_osc_enable_i,
  input  wire logic                     slow_osc_disable_i,
  input  wire logic [1:0]               subclock_pin_cfg_i,
  input  wire logic                     high_speed_source_select_i,
  input  wire logic                     low_speed_source_select_i,
  input  wire logic                     base_path_select_i,
  input  wire logic [SYS_DIV_WIDTH-1:0] system_divider_setting_i,
  input  wire logic [2:0]               cpu_divider_select_i,
  input  wire logic [1:0]               converter_divider_select_i,
  input  wire logic                     prescaler_halt_i,
  input  wire logic                     wait_clock_stop_i,
  input  wire logic                     wake_clock_switch_i,
  input  wire logic                     wait_mode_i,
  input  wire logic                     stop_mode_i,
  output logic                          fast_internal_clock_o,
  output logic                          slow_internal_clock_o,
  output logic                          subclock_source_o,
  output logic                          high_path_clock_o,
  output logic                          low_path_clock_o,
  output logic                          base_clock_o,
  output logic                          system_clock_o,
  output logic                          cpu_clock_o,
  output logic                          converter_clock_o,
  output logic [PRE_WIDTH:0]            periph_clock_o,
  output logic                          switch_busy_o
);

  if (SYS_DIV_WIDTH < 1 || SYS_DIV_WIDTH > 16) begin : g_bad_div
    $error("scg_top: SYS_DIV_WIDTH must lie between 1 and 16");
  end
  if (PRE_WIDTH < 1 || PRE_WIDTH > 16) begin : g_bad_pre
    $error("scg_top: PRE_WIDTH must lie between 1 and 16");
  end

  localparam int CPU_W = `SCG_CPU_DIV_WIDTH;

  typedef struct packed {
    scg_switch_state_type sw;
    scg_src_sel_type      cur;
    logic                 main_src;
    logic                 fast_src;
    logic                 slow_src;
    logic                 sub_src;
    logic                 high;
    logic                 low;
    logic                 base;
    logic                 sys;
    logic                 cpu;
    logic                 conv;
    logic [PRE_WIDTH:0]   periph;
    logic [PRE_WIDTH-1:0] pre;
    logic                 wait_prev;
    logic                 stop_prev;
    logic                 busy;
  } scg_top_state_type;

  scg_top_state_type s_q;
  scg_top_state_type s_d;

  logic sys_tick;
  logic cpu_tick;
  logic conv_tick;
  logic cpu_in;

  // Ratio minus one for a power-of-two code, clamped to the largest ratio.
  function automatic logic [CPU_W-1:0] pow2_m1(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `SCG_CPU_SEL_MAX) ? `SCG_CPU_SEL_MAX : code;
    return CPU_W'((6'h01 << c) - 6'h01);
  endfunction : pow2_m1

  // True when the low k prescaler bits are all ones.
  function automatic logic tap_hit(input logic [PRE_WIDTH-1:0] cnt,
                                   input int k);
    logic [PRE_WIDTH-1:0] mask;
    mask = PRE_WIDTH'((32'h1 << k) - 32'h1);
    return ((cnt & mask) == mask);
  endfunction : tap_hit

  always_comb begin
    scg_src_sel_type req;
    logic high_sel;
    logic low_sel;
    logic sel_tick;
    logic pass;
    logic per_stop;
    logic run;
    logic init;
    s_d  = s_q;
    req  = '{base_path:  base_path_select_i,
             high_speed: high_speed_source_select_i,
             low_speed:  low_speed_source_select_i};
    pass = 1'b0;
    high_sel = 1'b0;
    low_sel  = 1'b0;
    sel_tick = 1'b0;
    per_stop = 1'b0;
    run      = 1'b0;
    init     = 1'b0;

    // Source outputs; the crystal alone is stopped in stop mode.
    s_d.fast_src = fast_internal_clock_i & fast_osc_enable_i;
    s_d.slow_src = slow_internal_clock_i & ~slow_osc_disable_i;
    s_d.sub_src  = sub_crystal_clock_i &
                   ((subclock_pin_cfg_i == `SCG_SUBCLK_EXT) |
                    (subclock_pin_cfg_i == `SCG_SUBCLK_XTAL));
    s_d.main_src = main_crystal_clock_i & ~stop_mode_i;

    // Path multiplexers work on the applied selection only.
    high_sel = s_q.cur.high_speed ? s_q.fast_src
                                  : s_q.main_src;
    low_sel  = s_q.cur.low_speed ? s_q.sub_src
                                 : s_q.slow_src;
    sel_tick = s_q.cur.base_path ? high_sel : low_sel;
    s_d.high = high_sel;
    s_d.low  = low_sel;

    // The old source finishes its period, then the first tick of the new
    // source is swallowed so the next interval is a whole new period.
    // A source that is already dead would stall the switch, which is why
    // the new source must be running and stable before it is chosen.
    unique case (s_q.sw)
      SCG_SW_RUN: begin
        pass = 1'b1;
        if (req != s_q.cur) begin
          s_d.sw = SCG_SW_DRAIN;
        end
      end
      SCG_SW_DRAIN: begin
        pass = 1'b1;
        if (sel_tick) begin
          s_d.cur = req;
          s_d.sw  = SCG_SW_ARM;
        end
      end
      SCG_SW_ARM: begin
        if (sel_tick) begin
          s_d.sw = SCG_SW_RUN;
        end
      end
      default: begin
        s_d.sw = SCG_SW_RUN;
      end
    endcase
    s_d.busy = (s_d.sw != SCG_SW_RUN);
    s_d.base = pass & sel_tick & ~stop_mode_i;

    // Registered copies of the divider ticks.
    s_d.sys  = sys_tick;
    s_d.cpu  = cpu_tick;
    s_d.conv = conv_tick;

    // Prescaler control and peripheral taps.
    per_stop = wait_mode_i & wait_clock_stop_i;
    run      = ~prescaler_halt_i & ~per_stop &
               ~stop_mode_i;
    init     = (s_q.stop_prev & ~stop_mode_i) |
               (s_q.wait_prev & ~wait_mode_i & wake_clock_switch_i);
    s_d.wait_prev = wait_mode_i;
    s_d.stop_prev = stop_mode_i;
    if (init) begin
      s_d.pre    = '0;
      s_d.periph = '0;
    end else begin
      s_d.periph[0] = sys_tick & ~per_stop & ~stop_mode_i;
      for (int k = 1; k <= PRE_WIDTH; k++) begin
        s_d.periph[k] = sys_tick & run & tap_hit(s_q.pre, k);
      end
      if (sys_tick & run) begin
        s_d.pre = s_q.pre + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // The CPU stands still in both wait and stop mode.
  assign cpu_in = sys_tick & ~wait_mode_i & ~stop_mode_i;

  scg_divider #(
    .WIDTH (SYS_DIV_WIDTH)
  ) u_sys_div (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (s_q.base),
    .ratio_m1_i (system_divider_setting_i),
    .tick_o     (sys_tick)
  );

  scg_divider #(
    .WIDTH (CPU_W)
  ) u_cpu_div (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (cpu_in),
    .ratio_m1_i (pow2_m1(cpu_divider_select_i)),
    .tick_o     (cpu_tick)
  );

  scg_divider #(
    .WIDTH (CPU_W)
  ) u_conv_div (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (sys_tick),
    .ratio_m1_i (pow2_m1({1'b0, converter_divider_select_i})),
    .tick_o     (conv_tick)
  );

  // Reset applies the slow oscillator on the low path with no division.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q                <= '0;
      s_q.sw             <= SCG_SW_RUN;
      s_q.cur.base_path  <= `SCG_BASE_SEL_RST;
      s_q.cur.high_speed <= `SCG_HS_SEL_RST;
      s_q.cur.low_speed  <= `SCG_LS_SEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // The prescaler count has no port at all.
  assign fast_internal_clock_o = s_q.fast_src;
  assign slow_internal_clock_o = s_q.slow_src;
  assign subclock_source_o     = s_q.sub_src;
  assign high_path_clock_o     = s_q.high;
  assign low_path_clock_o      = s_q.low;
  assign base_clock_o          = s_q.base;
  assign system_clock_o        = s_q.sys;
  assign cpu_clock_o           = s_q.cpu;
  assign converter_clock_o     = s_q.conv;
  assign periph_clock_o        = s_q.periph;
  assign switch_busy_o         = s_q.busy;

endmodule : scg_top

`default_nettype wire

// ==== sim/scg_top_properties.sv ====
// Concurrent checks on the ports of the clock generation block.
`timescale 1ns/10ps
`default_nettype none

module scg_top_properties
  import scg_pkg::*;
#(
  parameter int PRE_WIDTH = 13
) (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               sub_crystal_clock_i,
  input wire logic               fast_internal_clock_i,
  input wire logic               slow_internal_clock_i,
  input wire logic               fast_osc_enable_i,
  input wire logic               slow_osc_disable_i,
  input wire logic [1:0]         subclock_pin_cfg_i,
  input wire logic               prescaler_halt_i,
  input wire logic               wait_clock_stop_i,
  input wire logic               wake_clock_switch_i,
  input wire logic               wait_mode_i,
  input wire logic               stop_mode_i,
  input wire logic               fast_internal_clock_o,
  input wire logic               slow_internal_clock_o,
  input wire logic               subclock_source_o,
  input wire logic               system_clock_o,
  input wire logic               cpu_clock_o,
  input wire logic [PRE_WIDTH:0] periph_clock_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Four edges cover the pipeline between a gating input and the tick outputs.
  sequence s_wait_gated;
    (wait_mode_i && wait_clock_stop_i) [*4];
  endsequence
  sequence s_halted;
    prescaler_halt_i [*4];
  endsequence

  property p_fast;
    $past(nrst_i) |->
      fast_internal_clock_o == $past(fast_internal_clock_i && fast_osc_enable_i);
  endproperty
  property p_slow;
    $past(nrst_i) |->
      slow_internal_clock_o == $past(slow_internal_clock_i && !slow_osc_disable_i);
  endproperty
  property p_sub;
    $past(nrst_i) |-> subclock_source_o == $past(sub_crystal_clock_i &&
      (subclock_pin_cfg_i == 2'h1 || subclock_pin_cfg_i == 2'h2));
  endproperty
  property p_wait_periph;
    s_wait_gated |-> periph_clock_o == '0;
  endproperty
  property p_halt;
    s_halted |-> periph_clock_o[PRE_WIDTH:1] == '0;
  endproperty
  property p_chain;
    (periph_clock_o[PRE_WIDTH:1] & ~periph_clock_o[PRE_WIDTH-1:0]) == '0;
  endproperty
  property p_sync;
    periph_clock_o[0] |-> system_clock_o;
  endproperty
  property p_init;
    ($fell(stop_mode_i) || ($fell(wait_mode_i) && wake_clock_switch_i)) |=>
      periph_clock_o[PRE_WIDTH:1] == '0;
  endproperty
  property p_pulse;
    cpu_clock_o |=> !cpu_clock_o;
  endproperty

  a_fast: assert property (p_fast) else $error("fast gate wrong");
  a_slow: assert property (p_slow) else $error("slow gate wrong");
  a_sub: assert property (p_sub) else $error("sub gate wrong");
  a_wait_periph: assert property (p_wait_periph)
    else $error("periph ran in wait");
  a_halt: assert property (p_halt) else $error("halted ticked");
  a_chain: assert property (p_chain) else $error("periph order");
  a_sync: assert property (p_sync) else $error("periph unsynced");
  a_init: assert property (p_init) else $error("no prescaler init");
  a_pulse: assert property (p_pulse) else $error("cpu pulse long");
endmodule : scg_top_properties

bind scg_top scg_top_properties #(
  .PRE_WIDTH (PRE_WIDTH)
) i_props (
  .clk_i                 (clk_i),
  .nrst_i                (nrst_i),
  .sub_crystal_clock_i   (sub_crystal_clock_i),
  .fast_internal_clock_i (fast_internal_clock_i),
  .slow_internal_clock_i (slow_internal_clock_i),
  .fast_osc_enable_i     (fast_osc_enable_i),
  .slow_osc_disable_i    (slow_osc_disable_i),
  .subclock_pin_cfg_i    (subclock_pin_cfg_i),
  .prescaler_halt_i      (prescaler_halt_i),
  .wait_clock_stop_i     (wait_clock_stop_i),
  .wake_clock_switch_i   (wake_clock_switch_i),
  .wait_mode_i           (wait_mode_i),
  .stop_mode_i           (stop_mode_i),
  .fast_internal_clock_o (fast_internal_clock_o),
  .slow_internal_clock_o (slow_internal_clock_o),
  .subclock_source_o     (subclock_source_o),
  .system_clock_o        (system_clock_o),
  .cpu_clock_o           (cpu_clock_o),
  .periph_clock_o        (periph_clock_o)
);

`default_nettype wire

// ==== sim/test_scg_top.sv ====
// Self-checking bench for the clock generation block.
`timescale 1ns/10ps
`default_nettype none

`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %0d seen %0d", nm, e, g); end end

module test_scg_top
  import scg_pkg::*;
;
  logic clk_i = 1'b0, nrst_i = 1'b0, main_crystal_clock_i = 1'b0;
  logic sub_crystal_clock_i = 1'b0, fast_internal_clock_i = 1'b0;
  logic slow_internal_clock_i = 1'b0, fast_osc_enable_i = 1'b0;
  logic slow_osc_disable_i = 1'b0, high_speed_source_select_i = 1'b0;
  logic low_speed_source_select_i = 1'b0, base_path_select_i = 1'b0;
  logic prescaler_halt_i = 1'b0, wait_clock_stop_i = 1'b0;
  logic wake_clock_switch_i = 1'b0, wait_mode_i = 1'b0, stop_mode_i = 1'b0;
  logic [1:0]  subclock_pin_cfg_i = 2'h0, converter_divider_select_i = 2'h0;
  logic [7:0]  system_divider_setting_i = 8'h00;
  logic [2:0]  cpu_divider_select_i = 3'h0;
  logic fast_internal_clock_o, slow_internal_clock_o, subclock_source_o;
  logic high_path_clock_o, low_path_clock_o, base_clock_o, system_clock_o;
  logic cpu_clock_o, converter_clock_o, switch_busy_o;
  logic [13:0] periph_clock_o;
  logic [23:0] all_o;
  int          n_fail = 0, checks_done = 0, seed = 32'h93ff, cyc = 0;

  assign all_o = {fast_internal_clock_o, slow_internal_clock_o,
    subclock_source_o, high_path_clock_o, low_path_clock_o, base_clock_o,
    system_clock_o, cpu_clock_o, converter_clock_o, switch_busy_o,
    periph_clock_o};

  scg_top i_dut (
    .clk_i                      (clk_i),
    .nrst_i                     (nrst_i),
    .main_crystal_clock_i       (main_crystal_clock_i),
    .sub_crystal_clock_i        (sub_crystal_clock_i),
    .fast_internal_clock_i      (fast_internal_clock_i),
    .slow_internal_clock_i      (slow_internal_clock_i),
    .fast_osc_enable_i          (fast_osc_enable_i),
    .slow_osc_disable_i         (slow_osc_disable_i),
    .subclock_pin_cfg_i         (subclock_pin_cfg_i),
    .high_speed_source_select_i (high_speed_source_select_i),
    .low_speed_source_select_i  (low_speed_source_select_i),
    .base_path_select_i         (base_path_select_i),
    .system_divider_setting_i   (system_divider_setting_i),
    .cpu_divider_select_i       (cpu_divider_select_i),
    .converter_divider_select_i (converter_divider_select_i),
    .prescaler_halt_i           (prescaler_halt_i),
    .wait_clock_stop_i          (wait_clock_stop_i),
    .wake_clock_switch_i        (wake_clock_switch_i),
    .wait_mode_i                (wait_mode_i),
    .stop_mode_i                (stop_mode_i),
    .fast_internal_clock_o      (fast_internal_clock_o),
    .slow_internal_clock_o      (slow_internal_clock_o),
    .subclock_source_o          (subclock_source_o),
    .high_path_clock_o          (high_path_clock_o),
    .low_path_clock_o           (low_path_clock_o),
    .base_clock_o               (base_clock_o),
    .system_clock_o             (system_clock_o),
    .cpu_clock_o                (cpu_clock_o),
    .converter_clock_o          (converter_clock_o),
    .periph_clock_o             (periph_clock_o),
    .switch_busy_o              (switch_busy_o)
  );

  always #2.5 clk_i = ~clk_i;

  // Fixed source periods in cycles: crystal 3, sub 5, fast 2, slow 4.
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    main_crystal_clock_i <= cyc % 3 == 0;
    sub_crystal_clock_i <= cyc % 5 == 0;
    fast_internal_clock_i <= cyc % 2 == 0;
    slow_internal_clock_i <= cyc % 4 == 0;
  end

  function automatic int exp_gap(input int p, input int d, input int sh);
    return (p * (d + 1)) << sh;
  endfunction : exp_gap

  function automatic logic pick(input int w);
    case (w)
      -2: return low_path_clock_o;
      -1: return high_path_clock_o;
      0: return base_clock_o;
      1: return system_clock_o;
      2: return cpu_clock_o;
      3: return converter_clock_o;
      4: return subclock_source_o;
      5: return fast_internal_clock_o;
      6: return slow_internal_clock_o;
      default: return periph_clock_o[w-7];
    endcase
  endfunction : pick

  // The third tick is used so that a ratio taken mid-period cannot skew it.
  task automatic gap(input int w, input int lim, output int n);
    int t;
    n = -1;
    for (int i = 0; i < 3; i++) begin
      t = 0;
      do begin
        @(negedge clk_i);
        t++;
      end while (pick(w) !== 1'b1 && t < lim);
      if (pick(w) !== 1'b1) return;
    end
    n = t;
  endtask : gap

  task automatic settle;
    int t;
    t = 0;
    @(negedge clk_i);
    `CHECK("switch busy", 1, switch_busy_o)
    repeat (2) @(negedge clk_i);
    while (switch_busy_o !== 1'b0 && t < 2000) begin
      @(negedge clk_i);
      t++;
    end
    `CHECK("switch done", 0, switch_busy_o)
  endtask : settle

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    #(5 * 60000);
    n_fail++;
    wrap_up;
  end

  initial begin
    int n, d;
    repeat (5) @(negedge clk_i);
    `CHECK("reset outputs", 24'h0, all_o)
    nrst_i = 1'b1;
    @(negedge clk_i);
    // The slow tick sampled at the release edge already passes the gate.
    `CHECK("first edge outputs", 24'h400000, all_o)
    gap(2, 100, n);
    `CHECK("cpu after reset", 4, n)
    gap(0, 100, n);
    `CHECK("slow base", 4, n)
    system_divider_setting_i = 8'hff;
    gap(1, 2200, n);
    `CHECK("system gap max", exp_gap(4, 255, 0), n)
    for (int c = 0; c < 8; c++) begin
      d = $random(seed) & 3;
      system_divider_setting_i = 8'(d);
      cpu_divider_select_i = 3'(c);
      converter_divider_select_i = 2'(c);
      gap(2, 1200, n);
      `CHECK("cpu gap", exp_gap(4, d, c > 5 ? 5 : c), n)
      gap(3, 300, n);
      `CHECK("converter gap", exp_gap(4, d, c % 4), n)
    end
    system_divider_setting_i = 8'h00;
    converter_divider_select_i = 2'h0;
    for (int k = 0; k < 5; k++) begin
      gap(7 + k, 200, n);
      `CHECK("periph gap", exp_gap(4, 0, k), n)
    end
    prescaler_halt_i = 1'b1;
    gap(8, 100, n);
    `CHECK("halted periph", -1, n)
    gap(7, 100, n);
    `CHECK("f1 while halted", 4, n)
    prescaler_halt_i = 1'b0;
    fast_osc_enable_i = 1'b1;
    wait_clock_stop_i = 1'b1;
    wait_mode_i = 1'b1;
    gap(7, 100, n);
    `CHECK("periph in wait", -1, n)
    gap(3, 100, n);
    `CHECK("converter in wait", 4, n)
    gap(5, 50, n);
    `CHECK("fast in wait", 2, n)
    gap(6, 50, n);
    `CHECK("slow in wait", 4, n)
    wake_clock_switch_i = 1'b1;
    wait_mode_i = 1'b0;
    high_speed_source_select_i = 1'b1;
    base_path_select_i = 1'b1;
    settle;
    gap(0, 50, n);
    `CHECK("base on fast", 2, n)
    gap(-1, 50, n);
    `CHECK("high path fast", 2, n)
    high_speed_source_select_i = 1'b0;
    settle;
    gap(0, 50, n);
    `CHECK("base on crystal", 3, n)
    base_path_select_i = 1'b0;
    settle;
    gap(0, 50, n);
    `CHECK("base on slow", 4, n)
    gap(-1, 50, n);
    `CHECK("high path crystal", 3, n)
    gap(-2, 50, n);
    `CHECK("low path slow", 4, n)
    subclock_pin_cfg_i = 2'h2;
    low_speed_source_select_i = 1'b1;
    settle;
    gap(0, 50, n);
    `CHECK("base on sub", 5, n)
    stop_mode_i = 1'b1;
    gap(4, 50, n);
    `CHECK("sub in stop", 5, n)
    stop_mode_i = 1'b0;
    low_speed_source_select_i = 1'b0;
    settle;
    subclock_pin_cfg_i = 2'h0;
    gap(4, 50, n);
    `CHECK("sub off", -1, n)
    slow_osc_disable_i = 1'b1;
    gap(6, 50, n);
    `CHECK("slow off", -1, n)
    wrap_up;
  end
endmodule : test_scg_top

`default_nettype wire
